// File: acs_pkg.sv
// Constants, register map and types of the converter sequencer control
package acs_pkg;
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_GEN = 8'h04;
   localparam logic [7:0] OFS_CFG = 8'h08;
   localparam logic [7:0] OFS_WARM = 8'h0c;
   localparam logic [7:0] OFS_MODE = 8'h10;
   localparam logic [7:0] OFS_SCAN_LO = 8'h18;
   localparam logic [7:0] OFS_SCAN_HI = 8'h1c;
   localparam logic [7:0] OFS_STAT = 8'h2c;
   // Reset values
   localparam logic [31:0] RST_CMD = 32'h0000_0000;
   localparam logic [31:0] RST_GEN = 32'h0000_0001;
   localparam logic [31:0] RST_CFG = 32'h0000_0100;
   localparam logic [31:0] RST_WARM = 32'h0000_000f;
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   // Writable bits per register
   localparam logic [31:0] MSK_GEN = 32'h0000_3f3f;
   localparam logic [31:0] MSK_CFG = 32'h001f_ff1f;
   localparam logic [31:0] MSK_WARM = 32'h0000_003f;
   localparam logic [31:0] MSK_MODE = 32'h0000_0400;
   localparam logic [31:0] MSK_ALL = 32'hffff_ffff;
   // Field positions
   localparam int CMD_GO = 0;
   localparam int CMD_BLK_RST = 1;
   localparam int CMD_CLK_RST = 2;
   localparam int GEN_EN = 1;
   localparam int GEN_FAST_INV = 3;
   localparam int GEN_SLOW_INV = 4;
   localparam int GEN_CAL = 5;
   localparam int GEN_DIV_LSB = 8;
   localparam int CFG_TRIG_LSB = 0;
   localparam int CFG_TRIG_EN = 4;
   localparam int CFG_CONT = 8;
   localparam int CFG_FMT = 9;
   localparam int CFG_CAL_REF = 10;
   localparam int CFG_CAL_CLR = 11;
   localparam int CFG_CAL_SRC = 12;
   localparam int CFG_AVG_LSB = 13;
   localparam int CFG_SCAN_LSB = 16;
   localparam int CFG_PWR = 20;
   localparam int WARM_LSB = 0;
   localparam int WARM_BYP = 5;
   localparam int MODE_DIFF = 10;
   // Timing: one microsecond, rounded up to whole clocks
   localparam int CLK_PERIOD_NS = 40;
   localparam int US_NS = 1000;
   localparam int US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0] US_LAST = 5'(US_CYCLES - 1);
   localparam logic [2:0] AVG_MAX = 3'h4;
   // Sequencer states
   typedef enum logic [1:0] {S_IDLE, S_WARM, S_REQ, S_WAIT} acs_state_t;
endpackage

// File: acs_div_if.sv
// Control link between the register file and the analog clock divider
`timescale 1ns/1ps
interface acs_div_if;
   logic [5:0] ratio;
   logic restart;
   logic tick;
   modport ctl (output ratio, output restart, input tick);
   modport div (input ratio, input restart, output tick);
endinterface

// File: acs_trig_sync.sv
// Three-stage synchronisers for the external trigger levels
`timescale 1ns/1ps
module acs_trig_sync import acs_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Levels in and filtered levels out
   input wire logic [3:0] lvl_in,
   output logic [3:0] lvl_out
);
   genvar i;
   // Output follows only once stages two and three agree
   for (i = 0; i < 4; i++) begin : g_bit
      logic s1_q, s2_q, s3_q, o_q, o_d;
      always_comb begin
         o_d = (s2_q == s3_q) ? s3_q : o_q;
      end
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            o_q <= 1'b0;
         end else begin
            s1_q <= lvl_in[i];
            s2_q <= s1_q;
            s3_q <= s2_q;
            o_q <= o_d;
         end
      end
      assign lvl_out[i] = o_q;
   end
endmodule

// File: acs_clkdiv.sv
// Programmable divider that makes the analog clock enable pulse
`timescale 1ns/1ps
module acs_clkdiv import acs_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Control link
   acs_div_if.div dif
);
   logic [5:0] cnt_q, cnt_d, lim;
   logic tick_q, tick_d;

   // Codes 0 and 1 both divide by one
   always_comb begin
      lim = (dif.ratio < 6'h02) ? 6'h01 : dif.ratio;
      cnt_d = cnt_q + 6'h01;
      tick_d = 1'b0;
      if (dif.restart) begin
         cnt_d = 6'h00;
      end else if (cnt_q + 6'h01 >= lim) begin
         cnt_d = 6'h00;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= 6'h00;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end
   assign dif.tick = tick_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   div_by_one_a: assert property (@(posedge clk) disable iff (!rst_b)
      (dif.ratio < 6'h02 && !dif.restart) |=> dif.tick)
      else $error("divide-by-one missed a tick");
   div_gap_a: assert property (@(posedge clk) disable iff (!rst_b)
      (dif.tick && dif.ratio > 6'h02 && $stable(dif.ratio)) |=> !dif.tick)
      else $error("divider ticked too soon");
endmodule

// File: acs_top.sv
// Converter sequencer control: Avalon register file, power, warm-up and scan
`timescale 1ns/1ps
module acs_top import acs_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Avalon-MM slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Analog core control
   output logic an_clk_en,
   output logic slow_analog_clock_invert,
   output logic fast_analog_clock_invert,
   output logic bias_ref_on,
   output logic conv_req,
   output logic [3:0] slot_input_select,
   output logic diff_mode,
   input wire logic sample_done,
   input wire logic [15:0] sample_data,
   // Calibration
   output logic cal_req,
   input wire logic cal_done,
   output logic cal_data_clear,
   output logic cal_use_user,
   output logic cal_ext_vref,
   output logic format_unsigned,
   // Result stream
   output logic fifo_clear,
   output logic result_valid,
   output logic [15:0] result_data,
   output logic [3:0] result_slot,
   // External triggers
   input wire logic [3:0] trig_in,
   output logic data_valid
);
   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   acs_div_if dif ();
   logic [3:0] trig_lvl;
   logic ack_q, ack_d;
   logic [31:0] rdata_q, rdata_d;
   logic go_q, go_d;
   logic [31:0] gen_q, gen_d, cfg_q, cfg_d, warm_q, warm_d, mode_q, mode_d;
   logic [31:0] scan_lo_q, scan_lo_d, scan_hi_q, scan_hi_d;
   logic blk_q, blk_d, crst_q, crst_d, fclr_q, fclr_d, cclr_q, cclr_d;
   logic bias_q, bias_d;
   logic wr, go_evt;
   logic [31:0] wd, be_m;
   acs_state_t st_q, st_d;
   logic [4:0] usc_q, usc_d, us_q, us_d;
   logic [3:0] slot_q, slot_d, avg_q, avg_d;
   logic [19:0] acc_q, acc_d, sum;
   logic [15:0] res_q, res_d;
   logic [3:0] rslot_q, rslot_d;
   logic rv_q, rv_d;
   logic [2:0] avg_sh;
   logic [3:0] avg_last, scan_len, trig_sel;
   logic trig_ok, en, req_now;

   ////////////////////////////////////////////////////////////////////////////
   // Submodules
   acs_clkdiv u_div (
      .clk (clk),
      .rst_b (rst_b),
      .dif (dif)
   );
   acs_trig_sync u_sync (
      .clk (clk),
      .rst_b (rst_b),
      .lvl_in (trig_in),
      .lvl_out (trig_lvl)
   );
   assign dif.ratio = gen_q[GEN_DIV_LSB +: 6];
   assign dif.restart = crst_q;

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave: one wait cycle, the write lands on the released edge
   assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
   assign wr = avs_write & ack_q;
   assign wd = avs_writedata;
   assign be_m = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign go_evt = wr && avs_address == OFS_CMD && avs_byteenable[0] && wd[CMD_GO];

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] val,
                                         input logic [31:0] m);
      return (old & ~m) | (val & m);
   endfunction

   // Read mux, unmapped addresses answer zero
   always_comb begin
      ack_d = (avs_read | avs_write) & ~ack_q;
      rdata_d = rdata_q;
      if (avs_read && !ack_q) begin
         case (avs_address)
            OFS_CMD: rdata_d = {31'h0, go_q};
            OFS_GEN: rdata_d = gen_q;
            OFS_CFG: rdata_d = cfg_q;
            OFS_WARM: rdata_d = warm_q;
            OFS_MODE: rdata_d = mode_q;
            OFS_SCAN_LO: rdata_d = scan_lo_q;
            OFS_SCAN_HI: rdata_d = scan_hi_q;
            OFS_STAT: rdata_d = {24'h0, slot_q, bias_q, gen_q[GEN_CAL],
                                 st_q == S_WARM, st_q != S_IDLE};
            default: rdata_d = 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register file next values
   always_comb begin
      go_d = go_q;
      gen_d = gen_q;
      cfg_d = cfg_q;
      warm_d = warm_q;
      mode_d = mode_q;
      scan_lo_d = scan_lo_q;
      scan_hi_d = scan_hi_q;
      blk_d = 1'b0;
      crst_d = 1'b0;
      cclr_d = 1'b0;
      fclr_d = go_evt;
      // Hardware clears the calibration bit; a same-cycle write to GEN wins
      if (cal_done) begin
         gen_d[GEN_CAL] = 1'b0;
      end
      if (wr) begin
         case (avs_address)
            OFS_CMD: begin
               if (avs_byteenable[0]) begin
                  go_d = wd[CMD_GO];
                  blk_d = wd[CMD_BLK_RST];
                  crst_d = wd[CMD_CLK_RST];
               end
            end
            OFS_GEN: gen_d = merge(gen_q, wd, be_m & MSK_GEN);
            OFS_CFG: begin
               cfg_d = merge(cfg_q, wd, be_m & MSK_CFG);
               cclr_d = avs_byteenable[1] & wd[CFG_CAL_CLR];
            end
            OFS_WARM: warm_d = merge(warm_q, wd, be_m & MSK_WARM);
            OFS_MODE: mode_d = merge(mode_q, wd, be_m & MSK_MODE);
            OFS_SCAN_LO: scan_lo_d = merge(scan_lo_q, wd, be_m & MSK_ALL);
            OFS_SCAN_HI: scan_hi_d = merge(scan_hi_q, wd, be_m & MSK_ALL);
            default: ;
         endcase
      end
      // Power mode selects whether conversions must be running
      bias_d = gen_q[GEN_EN] & (cfg_q[CFG_PWR] | go_q);
   end

   // Block reset clears every control register, the divider included
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_q <= 1'b0;
         rdata_q <= RST_ZERO;
         go_q <= RST_CMD[CMD_GO];
         gen_q <= RST_GEN;
         cfg_q <= RST_CFG;
         warm_q <= RST_WARM;
         mode_q <= RST_ZERO;
         scan_lo_q <= RST_ZERO;
         scan_hi_q <= RST_ZERO;
         blk_q <= 1'b0;
         crst_q <= 1'b0;
         fclr_q <= 1'b0;
         cclr_q <= 1'b0;
         bias_q <= 1'b0;
      end else if (blk_q) begin
         ack_q <= ack_d;
         rdata_q <= rdata_d;
         go_q <= RST_CMD[CMD_GO];
         gen_q <= RST_GEN;
         cfg_q <= RST_CFG;
         warm_q <= RST_WARM;
         mode_q <= RST_ZERO;
         scan_lo_q <= RST_ZERO;
         scan_hi_q <= RST_ZERO;
         blk_q <= 1'b0;
         crst_q <= 1'b1;
         fclr_q <= 1'b1;
         cclr_q <= 1'b0;
         bias_q <= 1'b0;
      end else begin
         ack_q <= ack_d;
         rdata_q <= rdata_d;
         go_q <= go_d;
         gen_q <= gen_d;
         cfg_q <= cfg_d;
         warm_q <= warm_d;
         mode_q <= mode_d;
         scan_lo_q <= scan_lo_d;
         scan_hi_q <= scan_hi_d;
         blk_q <= blk_d;
         crst_q <= crst_d;
         fclr_q <= fclr_d;
         cclr_q <= cclr_d;
         bias_q <= bias_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Static outputs toward the analog core
   assign avs_readdata = rdata_q;
   assign an_clk_en = dif.tick;
   assign slow_analog_clock_invert = gen_q[GEN_SLOW_INV];
   assign fast_analog_clock_invert = gen_q[GEN_FAST_INV];
   assign bias_ref_on = bias_q;
   assign cal_req = gen_q[GEN_CAL];
   assign cal_data_clear = cclr_q;
   assign cal_use_user = cfg_q[CFG_CAL_SRC];
   assign cal_ext_vref = cfg_q[CFG_CAL_REF];
   assign format_unsigned = cfg_q[CFG_FMT];
   assign diff_mode = mode_q[MODE_DIFF];
   assign fifo_clear = fclr_q;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer decode
   assign en = gen_q[GEN_EN];
   assign scan_len = cfg_q[CFG_SCAN_LSB +: 4];
   assign trig_sel = cfg_q[CFG_TRIG_LSB +: 4];
   // Reserved trigger codes never open the gate
   assign trig_ok = !cfg_q[CFG_TRIG_EN] ||
                    (trig_sel < 4'h4 && trig_lvl[trig_sel[1:0]]);
   assign req_now = st_q == S_REQ && dif.tick && trig_ok;
   assign conv_req = req_now;
   // Reserved averaging codes are clamped to sixteen samples
   assign avg_sh = (cfg_q[CFG_AVG_LSB +: 3] > AVG_MAX) ? AVG_MAX
                   : cfg_q[CFG_AVG_LSB +: 3];
   assign avg_last = 4'((5'h01 << avg_sh) - 5'h01);
   assign sum = acc_q + {4'h0, sample_data};
   // Slot code comes from the two scan registers
   assign slot_input_select = slot_q[3] ? scan_hi_q[slot_q[2:0] * 4 +: 4]
                                        : scan_lo_q[slot_q[2:0] * 4 +: 4];

   // Warm-up, request, sample accumulate and scan advance
   always_comb begin
      st_d = st_q;
      usc_d = usc_q;
      us_d = us_q;
      slot_d = slot_q;
      avg_d = avg_q;
      acc_d = acc_q;
      res_d = res_q;
      rslot_d = rslot_q;
      rv_d = 1'b0;
      case (st_q)
         S_IDLE: ;
         S_WARM: begin
            usc_d = usc_q + 5'h01;
            if (usc_q == US_LAST) begin
               usc_d = 5'h00;
               us_d = us_q + 5'h01;
               if (us_q == warm_q[WARM_LSB +: 5]) begin
                  st_d = S_REQ;
               end
            end
         end
         S_REQ: begin
            if (req_now) begin
               st_d = S_WAIT;
            end
         end
         S_WAIT: begin
            if (sample_done) begin
               acc_d = sum;
               avg_d = avg_q + 4'h1;
               st_d = S_REQ;
               if (avg_q == avg_last) begin
                  res_d = 16'(sum >> avg_sh);
                  rslot_d = slot_q;
                  rv_d = 1'b1;
                  acc_d = 20'h0;
                  avg_d = 4'h0;
                  slot_d = slot_q + 4'h1;
                  if (slot_q == scan_len) begin
                     slot_d = 4'h0;
                     if (!cfg_q[CFG_CONT]) begin
                        st_d = S_IDLE;
                     end
                  end
               end
            end
         end
         default: st_d = S_IDLE;
      endcase
      // A go write restarts the scan from its first slot
      if (go_evt && en) begin
         st_d = warm_q[WARM_BYP] ? S_REQ : S_WARM;
         usc_d = 5'h00;
         us_d = 5'h00;
         slot_d = 4'h0;
         avg_d = 4'h0;
         acc_d = 20'h0;
      end else if (!go_q || !en) begin
         st_d = S_IDLE;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= S_IDLE;
         usc_q <= 5'h00;
         us_q <= 5'h00;
         slot_q <= 4'h0;
         avg_q <= 4'h0;
         acc_q <= 20'h0;
         res_q <= 16'h0;
         rslot_q <= 4'h0;
         rv_q <= 1'b0;
      end else if (blk_q) begin
         st_q <= S_IDLE;
         usc_q <= 5'h00;
         us_q <= 5'h00;
         slot_q <= 4'h0;
         avg_q <= 4'h0;
         acc_q <= 20'h0;
         res_q <= 16'h0;
         rslot_q <= 4'h0;
         rv_q <= 1'b0;
      end else begin
         st_q <= st_d;
         usc_q <= usc_d;
         us_q <= us_d;
         slot_q <= slot_d;
         avg_q <= avg_d;
         acc_q <= acc_d;
         res_q <= res_d;
         rslot_q <= rslot_d;
         rv_q <= rv_d;
      end
   end
   assign result_valid = rv_q;
   assign result_data = res_q;
   assign result_slot = rslot_q;
   assign data_valid = rv_q & cfg_q[CFG_TRIG_EN];

   ////////////////////////////////////////////////////////////////////////////
   // Checks; the warm-up counter is helper logic for them only
   logic [9:0] wcnt_q;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wcnt_q <= 10'h0;
      end else begin
         wcnt_q <= (st_q == S_WARM) ? wcnt_q + 10'h1 : 10'h0;
      end
   end

   go_clears_fifo_a: assert property (@(posedge clk) disable iff (!rst_b)
      (go_evt && !blk_q) |=> fifo_clear)
      else $error("go write did not clear the fifo");
   block_reset_a: assert property (@(posedge clk) disable iff (!rst_b)
      blk_q |=> (gen_q == RST_GEN && cfg_q == RST_CFG && st_q == S_IDLE))
      else $error("block reset left state behind");
   cal_autoclear_a: assert property (@(posedge clk) disable iff (!rst_b)
      (cal_done && !wr && !blk_q) |=> !cal_req)
      else $error("calibration bit not cleared");
   bias_mode0_a: assert property (@(posedge clk) disable iff (!rst_b)
      (!cfg_q[CFG_PWR] && !go_q && !blk_q) |=> !bias_ref_on)
      else $error("bias on without conversions in mode zero");
   bias_mode1_a: assert property (@(posedge clk) disable iff (!rst_b)
      (cfg_q[CFG_PWR] && en && $stable(cfg_q) && $stable(gen_q) && !blk_q) |=> bias_ref_on)
      else $error("bias off in mode one");
   warm_length_a: assert property (@(posedge clk) disable iff (!rst_b)
      (st_q == S_WARM && st_d == S_REQ && !go_evt) |->
         wcnt_q == 10'((warm_q[4:0] + 10'h1) * US_CYCLES - 1))
      else $error("warm-up length wrong");
   warm_bypass_a: assert property (@(posedge clk) disable iff (!rst_b)
      (go_evt && en && warm_q[WARM_BYP] && !blk_q) |=> st_q == S_REQ)
      else $error("bypass did not skip warm-up");
   trig_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
      (conv_req && cfg_q[CFG_TRIG_EN]) |-> trig_lvl[trig_sel[1:0]])
      else $error("conversion without trigger level");
   scan_wrap_a: assert property (@(posedge clk) disable iff (!rst_b)
      (rv_d && slot_q == scan_len && !go_evt) ##1 (st_q != S_IDLE) |-> slot_q == 4'h0)
      else $error("scan did not wrap at its length");
   one_shot_a: assert property (@(posedge clk) disable iff (!rst_b)
      (rv_d && slot_q == scan_len && !cfg_q[CFG_CONT] && !go_evt && !blk_q)
         |=> st_q == S_IDLE ##1 !conv_req)
      else $error("one-shot scan kept converting");

   run_cover_c: cover property (@(posedge clk) disable iff (!rst_b)
      st_q == S_WARM ##[1:900] result_valid);
   trig_cover_c: cover property (@(posedge clk) disable iff (!rst_b)
      data_valid);
   cal_cover_c: cover property (@(posedge clk) disable iff (!rst_b)
      cal_req ##1 cal_done ##1 !cal_req);
endmodule

// File: acs_core_model.sv
// Behavioural analog core that answers sample and calibration requests
`timescale 1ns/1ps
module acs_core_model #(
   parameter int LAT = 3,
   parameter logic [15:0] DATA = 16'h1234
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Requests from the control block
   input wire logic conv_req,
   input wire logic cal_req,
   // Answers to the control block
   output logic sample_done,
   output logic [15:0] sample_data,
   output logic cal_done
);
   int cnt_q;
   int cal_q;
   // Fixed latency per sample, ten cycles per calibration
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= 0;
         cal_q <= 0;
         sample_done <= 1'b0;
         cal_done <= 1'b0;
      end else begin
         sample_done <= (cnt_q == 1);
         cnt_q <= conv_req ? LAT : (cnt_q > 0 ? cnt_q - 1 : 0);
         cal_done <= (cal_q == 1);
         cal_q <= (cal_req && cal_q == 0 && !cal_done) ? 10 : (cal_q > 0 ? cal_q - 1 : 0);
      end
   end
   // Data only valid with the strobe, so a stale value is never read as good
   assign sample_data = sample_done ? DATA : ~DATA;
endmodule

// File: adc_sequencer_control_tb.sv
// Self-checking bench for the converter sequencer control
`timescale 1ns/1ps
module adc_sequencer_control_tb import acs_pkg::*;;
   logic clk = 0, rst_b = 0, avs_read = 0, avs_write = 0;
   logic [7:0] avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
   logic [3:0] trig_in = 4'h0, slot_input_select, result_slot;
   logic avs_waitrequest, an_clk_en, slow_analog_clock_invert, fast_analog_clock_invert;
   logic bias_ref_on, conv_req, diff_mode, sample_done, cal_req, cal_done, cal_data_clear;
   logic cal_use_user, cal_ext_vref, format_unsigned, fifo_clear, result_valid, data_valid;
   logic [15:0] sample_data, result_data;
   int n_mismatch = 0, compares = 0, n_conv = 0, n_res = 0, n_dv = 0, n_ccl = 0, n_fc = 0;
   int gap = 0, per = 0, c0, c1;
   int dv[5] = '{0, 1, 2, 5, 32};
   always #20 clk = ~clk;
   acs_top dut (.clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest, .an_clk_en,
      .slow_analog_clock_invert, .fast_analog_clock_invert, .bias_ref_on, .conv_req,
      .slot_input_select, .diff_mode, .sample_done, .sample_data, .cal_req, .cal_done,
      .cal_data_clear, .cal_use_user, .cal_ext_vref, .format_unsigned, .fifo_clear,
      .result_valid, .result_data, .result_slot, .trig_in, .data_valid);
   acs_core_model core (.clk, .rst_b, .conv_req, .cal_req, .sample_done, .sample_data,
      .cal_done);
   ////////////////////////////////////////////////////////////////////////////////////
   // Pulse counters and divider period, so short pulses are never missed
   always @(posedge clk) begin
      n_conv <= n_conv + (conv_req === 1'b1);
      n_res <= n_res + (result_valid === 1'b1);
      n_dv <= n_dv + (data_valid === 1'b1);
      n_ccl <= n_ccl + (cal_data_clear === 1'b1);
      n_fc <= n_fc + (fifo_clear === 1'b1);
      gap <= (an_clk_en === 1'b1) ? 1 : gap + 1;
      if (an_clk_en === 1'b1) per <= gap;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One bus cycle; an idle edge first keeps requests from touching
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      // Hold the request until waitrequest is seen low; only the watchdog ends a hang
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task automatic wrap_up;
      $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      rdc(OFS_CMD, 32'h0);
      rdc(OFS_GEN, 32'h1);
      rdc(OFS_CFG, 32'h100);
      rdc(OFS_WARM, 32'hf);
      bus(1'b1, 8'h40, 32'hffff_ffff);
      rdc(8'h40, 32'h0);
      $display("test reset values done");
      for (int i = 0; i < 5; i++) begin
         bus(1'b1, OFS_GEN, 32'h7 | (dv[i] << 8));
         repeat (70) @(posedge clk);
         chk(per, dv[i] < 2 ? 1 : dv[i]);
      end
      bus(1'b1, OFS_CMD, 32'h4);
      rdc(OFS_GEN, 32'h2007);
      bus(1'b1, OFS_GEN, 32'h17);
      repeat (2) @(posedge clk);
      chk({slow_analog_clock_invert, fast_analog_clock_invert}, 2'b10);
      bus(1'b1, OFS_GEN, 32'h0f);
      repeat (2) @(posedge clk);
      chk({slow_analog_clock_invert, fast_analog_clock_invert}, 2'b01);
      bus(1'b1, OFS_CFG, 32'h1e00);
      repeat (2) @(posedge clk);
      chk({cal_use_user, cal_ext_vref, format_unsigned}, 3'b111);
      chk(n_ccl, 1);
      bus(1'b1, OFS_CFG, 32'h10_0000);
      repeat (3) @(posedge clk);
      chk(bias_ref_on, 1'b1);
      bus(1'b1, OFS_CFG, 32'h0);
      repeat (3) @(posedge clk);
      chk(bias_ref_on, 1'b0);
      $display("test controls done");
      // Warm-up lengths, then the bypass
      for (int t = 0; t < 2; t++) begin
         bus(1'b1, OFS_WARM, t);
         c0 = n_conv;
         c1 = n_fc;
         bus(1'b1, OFS_CMD, 32'h1);
         repeat (25 * (t + 1) - 5) @(posedge clk);
         chk(n_conv - c0, 0);
         chk(bias_ref_on, 1'b1);
         chk(n_fc - c1, 1);
         repeat (15) @(posedge clk);
         chk(n_conv > c0, 1);
         bus(1'b1, OFS_CMD, 32'h0);
      end
      bus(1'b1, OFS_WARM, 32'h3f);
      c0 = n_conv;
      bus(1'b1, OFS_CMD, 32'h1);
      repeat (8) @(posedge clk);
      chk(n_conv > c0, 1);
      bus(1'b1, OFS_CMD, 32'h0);
      $display("test warm-up done");
      // One-shot scan of three slots, two samples averaged per slot
      // An odd slot count is legal here, the packed result format is never chosen
      bus(1'b1, OFS_CFG, 32'h2_2000);
      c0 = n_conv;
      c1 = n_res;
      bus(1'b1, OFS_CMD, 32'h1);
      repeat (200) @(posedge clk);
      chk(n_res - c1, 3);
      chk(n_conv - c0, 6);
      chk({result_slot, result_data}, 20'h2_1234);
      bus(1'b1, OFS_CFG, 32'h100);
      c1 = n_res;
      bus(1'b1, OFS_CMD, 32'h1);
      repeat (100) @(posedge clk);
      chk(n_res - c1 > 5, 1);
      bus(1'b1, OFS_CMD, 32'h0);
      repeat (5) @(posedge clk);
      c0 = n_conv;
      repeat (50) @(posedge clk);
      chk(n_conv - c0, 0);
      $display("test scan done");
      // Every trigger source, first held low with the other three high, then raised alone
      for (int s = 0; s < 4; s++) begin
         trig_in <= ~(4'h1 << s);
         bus(1'b1, OFS_CFG, 32'h110 | s);
         c0 = n_conv;
         c1 = n_dv;
         bus(1'b1, OFS_CMD, 32'h1);
         repeat (40) @(posedge clk);
         chk(n_conv - c0, 0);
         trig_in <= 4'h1 << s;
         repeat (60) @(posedge clk);
         chk(n_dv > c1, 1);
         bus(1'b1, OFS_CMD, 32'h0);
      end
      $display("test triggers done");
      bus(1'b1, OFS_GEN, 32'h27);
      repeat (2) @(posedge clk);
      chk(cal_req, 1'b1);
      repeat (30) @(posedge clk);
      rdc(OFS_GEN, 32'h7);
      bus(1'b1, OFS_MODE, 32'h400);
      bus(1'b1, OFS_SCAN_LO, 32'h9);
      repeat (2) @(posedge clk);
      chk({diff_mode, slot_input_select}, 5'h19);
      bus(1'b1, OFS_CMD, 32'h2);
      rdc(OFS_GEN, 32'h1);
      rdc(OFS_CFG, 32'h100);
      rdc(OFS_MODE, 32'h0);
      rdc(OFS_STAT, 32'h0);
      $display("test calibration and block reset done");
      wrap_up();
   end
   // Watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      wrap_up();
   end
endmodule
